// ===== logic/edge_sync.sv
/*
  Two-flop synchroniser with falling-edge detector for a pin group.
  Assumes pins are asynchronous to clk_i.
*/
module edge_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] fall_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '1;
      sync <= '1;
      prev <= '1;
    end else begin
      meta <= pin_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_o = sync;
  assign fall_o  = prev & ~sync;
endmodule

// ===== logic/port_change.sv
/*
  Port input change detector against a reference latched on port read or reported change.
  Assumes synchronised pin levels and same-clock strobes.
*/
module port_change #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] level_i,
  input  wire logic [WIDTH-1:0] is_output_i,
  input  wire logic             ext_sel_i,
  input  wire logic             port_read_i,
  output logic                  change_o
);
  logic [WIDTH-1:0] ref_level;
  logic [WIDTH-1:0] watch;

  // Reference follows each port read and each reported change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_level <= '1;
    end else if (port_read_i || change_o) begin
      ref_level <= level_i;
    end
  end

  always_comb begin
    watch    = ~is_output_i;
    watch[0] = watch[0] & ~ext_sel_i;
  end

  assign change_o = |((level_i ^ ref_level) & watch);
endmodule

// ===== logic/reset_irq.sv
/*
  Reset-cause flags and interrupt controller of a small 8-bit core,
  with a classic Wishbone register slave.
  Assumes the core sequencer pulses instruction strobes for one cycle,
  and that power-on, pin and watchdog reset events are same-clock.
*/
`include "reset_irq_defs.svh"
module reset_irq
  import reset_irq_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 power_on_i,
  input  wire logic                 reset_pin_event_i,
  input  wire logic                 watchdog_expire_i,
  input  wire reset_irq_pkg::instr_t instr_i,
  input  wire logic [`RI_PC_W-1:0]  pc_i,
  input  wire logic                 timer_counter_ovf_i,
  input  wire logic [PORT_W-1:0]    port6_pin_i,
  input  wire logic                 port_read_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      core_reset_o,
  output logic                      sleeping_o,
  output reset_irq_pkg::vector_t    vector_o,
  output reset_irq_pkg::cause_t     cause_o
);
  import reset_irq_pkg::*;

  // -------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------
  cause_t              cause;
  run_state_t          state;
  logic [2:0]          flags;
  logic [2:0]          mask;
  logic                gie;
  logic                ext_sel;
  logic [PORT_W-1:0]   port_dir;
  logic [`RI_PC_W-1:0] ret_addr;
  logic [PORT_W-1:0]   level;
  logic [PORT_W-1:0]   fall;
  logic                change;
  logic                change_q;
  logic                timer_q;
  logic                any_reset;
  logic [2:0]          next_flags;
  logic [2:0]          pending;
  logic                take_irq;
  logic                take_swi;
  logic                wb_hit;
  logic                wr;
  logic [31:0]         rd_data;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] o);
    reg_hit = (a == o);
  endfunction

  // -------------------------------------------------------------
  // Pin inputs
  // -------------------------------------------------------------
  edge_sync #(.WIDTH(PORT_W)) pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (port6_pin_i),
    .level_o (level),
    .fall_o  (fall)
  );

  port_change #(.WIDTH(PORT_W)) pchg (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .level_i     (level),
    .is_output_i (~port_dir),
    .ext_sel_i   (ext_sel),
    .port_read_i (port_read_i),
    .change_o    (change)
  );

  // -------------------------------------------------------------
  // Reset causes
  // -------------------------------------------------------------
  assign any_reset = power_on_i | reset_pin_event_i | watchdog_expire_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause <= '{wake: 1'b0, timeout: 1'b1, powerdown: 1'b1};
    end else if (power_on_i) begin
      cause <= '{wake: 1'b0, timeout: 1'b1, powerdown: 1'b1};
    end else if (watchdog_expire_i) begin
      cause.wake    <= 1'b0;
      cause.timeout <= 1'b0;
      if (state == SLEEP_S) begin
        cause.powerdown <= 1'b0;
      end
    end else if (reset_pin_event_i) begin
      cause.wake <= 1'b0;
      if (state == SLEEP_S) begin
        cause.timeout   <= 1'b1;
        cause.powerdown <= 1'b0;
      end
    end else if (state == SLEEP_S && change && flags_en_port()) begin
      cause <= '{wake: 1'b1, timeout: 1'b1, powerdown: 1'b0};
    end else if (instr_i.wdt_clear) begin
      cause.timeout   <= 1'b1;
      cause.powerdown <= 1'b1;
    end else if (instr_i.sleep) begin
      cause.timeout   <= 1'b1;
      cause.powerdown <= 1'b0;
    end
  end

  function automatic logic flags_en_port();
    flags_en_port = mask[`RI_FL_PORT_BIT];
  endfunction

  // -------------------------------------------------------------
  // Run and sleep state
  // -------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= RUN_S;
    end else begin
      case (state)
        RUN_S: begin
          if (instr_i.sleep && !any_reset) begin
            state <= SLEEP_S;
          end
        end
        SLEEP_S: begin
          if (any_reset) begin
            state <= RUN_S;
          end else if (change && flags_en_port()) begin
            state <= WAKE_S;
          end
        end
        WAKE_S: begin
          state <= RUN_S;
        end
        default: begin
          state <= RUN_S;
        end
      endcase
    end
  end

  assign sleeping_o   = (state == SLEEP_S);
  assign core_reset_o = any_reset;
  assign cause_o      = cause;

  // -------------------------------------------------------------
  // Interrupt flags
  // -------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      change_q <= 1'b0;
      timer_q  <= 1'b0;
    end else begin
      change_q <= change;
      timer_q  <= timer_counter_ovf_i;
    end
  end

  assign wb_hit = wb_cyc_i & wb_stb_i;
  // Write lands on the edge at which the master samples ack high
  assign wr     = wb_hit & wb_we_i & wb_ack_o & wb_sel_i[0];

  always_comb begin
    next_flags = flags;
    if (wr && reg_hit(wb_adr_i, `RI_FLAGS_OFS)) begin
      next_flags = flags & wb_dat_i[2:0];
    end
    // Set wins over a clear in the same cycle
    if (timer_q && !timer_counter_ovf_i) begin
      next_flags[`RI_FL_TIMER_BIT] = 1'b1;
    end
    if (change && !change_q && mask[`RI_FL_PORT_BIT]) begin
      next_flags[`RI_FL_PORT_BIT] = 1'b1;
    end
    if (ext_sel && fall[0]) begin
      next_flags[`RI_FL_EXT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || any_reset) begin
      flags <= 3'h0;
    end else begin
      flags <= next_flags;
    end
  end

  // -------------------------------------------------------------
  // Global enable and vectors
  // -------------------------------------------------------------
  assign pending  = flags & mask;
  assign take_irq = gie && (|pending) && state != SLEEP_S;
  assign take_swi = gie && instr_i.soft_int && !take_irq;

  always_ff @(posedge clk_i) begin
    if (rst_i || any_reset) begin
      gie <= 1'b0;
    end else if (take_irq || take_swi) begin
      gie <= 1'b0;
    end else if (instr_i.enable_int || instr_i.ret_int) begin
      gie <= 1'b1;
    end else if (instr_i.disable_int) begin
      gie <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vector_o <= '0;
      ret_addr <= '0;
    end else begin
      vector_o.take <= take_irq | take_swi;
      if (take_irq) begin
        vector_o.addr <= `RI_VEC_IRQ;
        ret_addr      <= pc_i;
      end else if (take_swi) begin
        vector_o.addr <= `RI_VEC_SWI;
        ret_addr      <= pc_i;
      end
    end
  end

  // -------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || any_reset) begin
      mask     <= `RI_MASK_RST;
      ext_sel  <= 1'b0;
      port_dir <= `RI_DIR_RST;
    end else if (wr && reg_hit(wb_adr_i, `RI_MASK_OFS)) begin
      mask <= wb_dat_i[2:0];
    end else if (wr && reg_hit(wb_adr_i, `RI_CTRL_OFS)) begin
      ext_sel  <= wb_dat_i[`RI_CT_EXTSEL_BIT];
      port_dir <= wb_dat_i[15:8];
    end
  end

  // -------------------------------------------------------------
  // Wishbone slave
  // -------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0;
    case (wb_adr_i)
      `RI_STATUS_OFS: begin
        rd_data[`RI_ST_WAKE_BIT] = cause.wake;
        rd_data[`RI_ST_TO_BIT]   = cause.timeout;
        rd_data[`RI_ST_PD_BIT]   = cause.powerdown;
        rd_data[`RI_ST_GIE_BIT]  = gie;
        rd_data[`RI_ST_SLP_BIT]  = sleeping_o;
      end
      `RI_FLAGS_OFS: rd_data[2:0] = flags;
      `RI_MASK_OFS:  rd_data[2:0] = mask;
      `RI_CTRL_OFS: begin
        rd_data[`RI_CT_EXTSEL_BIT] = ext_sel;
        rd_data[15:8]              = port_dir;
      end
      `RI_RETADDR_OFS: rd_data[`RI_PC_W-1:0] = ret_addr;
      default: rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_hit & ~wb_ack_o;
      if (wb_hit && !wb_ack_o) begin
        wb_dat_o <= rd_data;
      end
    end
  end
endmodule

// ===== logic/reset_irq_defs.svh
/*
  Offsets, field positions, reset values and vectors of the reset-cause
  and interrupt logic.
  Assumes inclusion by bare name from the package and the modules.
*/
// Contract
// - Reset from power, reset pin, watchdog.
// - Power-on: wake flag 0, timeout 1, powerdown 1.
// - Pin reset running: clear wake, keep others.
// - Pin reset from sleep: 0, 1, 0.
// - Watchdog running: clear wake, timeout; keep powerdown.
// - Watchdog from sleep: all three flags 0.
// - Port change wake: 1, 1, 0.
// - Watchdog clear sets 1,1; sleep sets 1,0.
// - Three falling-edge sources: timer, port, external; the port flag here sets on a watched pin change in either direction.
// - Only input pins, not external pin, trigger.
// - Port change wakes; vector if enabled.
// - Enabled interrupt fetches from 008H; flags, masks.
// - Enable and disable instructions drive global enable.
// - Flags set regardless of mask, except port.
// - Effective request is flags AND mask.
// - Return instruction ends handler, sets enable.
// - Software interrupt fetches from 001H.
`ifndef RESET_IRQ_DEFS_SVH
`define RESET_IRQ_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define RI_STATUS_OFS   8'h00
`define RI_FLAGS_OFS    8'h04
`define RI_MASK_OFS     8'h08
`define RI_CTRL_OFS     8'h0c
`define RI_RETADDR_OFS  8'h10

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RI_ST_WAKE_BIT  2
`define RI_ST_TO_BIT    1
`define RI_ST_PD_BIT    0
`define RI_ST_GIE_BIT   3
`define RI_ST_SLP_BIT   4
`define RI_FL_TIMER_BIT 0
`define RI_FL_PORT_BIT  1
`define RI_FL_EXT_BIT   2
`define RI_CT_EXTSEL_BIT 0

// ---------------------------------------------------------------
// Reset values and vectors
// ---------------------------------------------------------------
`define RI_MASK_RST     3'h0
`define RI_DIR_RST      8'hff
`define RI_VEC_IRQ      10'h008
`define RI_VEC_SWI      10'h001
`define RI_PC_W         10

`endif

// ===== logic/reset_irq_pkg.sv
/*
  Types shared by the reset-cause and interrupt logic.
  Assumes reset_irq_defs.svh is on the include path.
*/
package reset_irq_pkg;
`include "reset_irq_defs.svh"

  // Core instruction strobes, one-cycle pulses
  typedef struct packed {
    logic wdt_clear;
    logic sleep;
    logic enable_int;
    logic disable_int;
    logic ret_int;
    logic soft_int;
  } instr_t;

  // Reset-cause flags
  typedef struct packed {
    logic wake;
    logic timeout;
    logic powerdown;
  } cause_t;

  // Vector request to the sequencer
  typedef struct packed {
    logic                 take;
    logic [`RI_PC_W-1:0]  addr;
  } vector_t;

  typedef enum logic [2:0] {
    RUN_S   = 3'b001,
    SLEEP_S = 3'b010,
    WAKE_S  = 3'b100
  } run_state_t;
endpackage

// ===== tb/core_seq_model.sv
/* Core sequencer model: strobes, program counter, vector log.
   Assumes the bench asks for one strobe set per cycle. */
module core_seq_model #(
  parameter logic [9:0] PC_HOLD = 10'h155
) (
  input  wire logic                   clk_i,
  input  wire reset_irq_pkg::instr_t  req_i,
  input  wire reset_irq_pkg::vector_t vector_i,
  output reset_irq_pkg::instr_t       instr_o,
  output logic [9:0]                  pc_o
);
  import reset_irq_pkg::*;
  int         n_take = 0;
  logic [9:0] last_addr = 10'h000;
  initial instr_o = '0;
  // Return address seen by the block
  assign pc_o = PC_HOLD;
  always @(posedge clk_i) begin
    instr_o <= req_i;
    if (vector_i.take === 1'b1) begin
      n_take <= n_take + 1;
      last_addr <= vector_i.addr;
    end
  end
endmodule

// ===== tb/reset_irq_bench.sv
/* Bench for reset_irq: bus, event and interrupt sequences.
   Assumes the checker is bound and the core model is present. */
module reset_irq_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import reset_irq_pkg::*;
  localparam instr_t i_wdclr = 6'h20, i_sleep = 6'h10, i_ei = 6'h08;
  localparam instr_t i_di = 6'h04, i_ret = 6'h02, i_swi = 6'h01;
  logic        clk_i = 1'b0, rst_i = 1'b1, po = 1'b0, pin_ev = 1'b0;
  logic        wd = 1'b0, tovf = 1'b0, prd = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, core_rst, slp;
  logic [7:0]  adr = 8'h00, pins = 8'hff;
  logic [31:0] dw = 32'h0, q, rdat;
  logic [9:0]  pc;
  instr_t      req = '0, instr;
  vector_t     vec;
  cause_t      cause;
  int          err_total = 0, n_checks = 0;
  always #20 clk_i = ~clk_i;
  reset_irq DUT (
    .clk_i(clk_i), .rst_i(rst_i), .power_on_i(po),
    .reset_pin_event_i(pin_ev), .watchdog_expire_i(wd),
    .instr_i(instr), .pc_i(pc), .timer_counter_ovf_i(tovf),
    .port6_pin_i(pins), .port_read_i(prd), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dw), .wb_dat_o(rdat), .wb_ack_o(ack),
    .core_reset_o(core_rst), .sleeping_o(slp), .vector_o(vec),
    .cause_o(cause)
  );
  core_seq_model u_core (
    .clk_i(clk_i), .req_i(req), .vector_i(vec), .instr_o(instr),
    .pc_o(pc)
  );
  // -----
  // Tasks
  // -----
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(q, e);
  endtask
  task automatic op(input instr_t v);
    @(posedge clk_i) req <= v;
    @(posedge clk_i) req <= '0;
    repeat (3) @(posedge clk_i);
  endtask
  // Events: 0 power, 1 pin, 2 watchdog, 3 port read
  task automatic pulse(input int k);
    @(posedge clk_i) {prd, wd, pin_ev, po} <= 4'h1 << k;
    @(posedge clk_i) {prd, wd, pin_ev, po} <= 4'h0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic pset(input logic [7:0] v);
    @(posedge clk_i) pins <= v;
    repeat (6) @(posedge clk_i);
  endtask
  // --------
  // Sequence
  // --------
  initial begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h03);
    rd(8'h08, 32'h0);
    rd(8'h20, 32'h0);
    @(posedge clk_i) tovf <= 1'b1;
    @(posedge clk_i) tovf <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(8'h04, 32'h1);
    op(i_ei);
    rd(8'h00, 32'h0b);
    check(u_core.n_take, 32'h0);
    wb(1'b1, 8'h08, 32'h1);
    repeat (4) @(posedge clk_i);
    check(u_core.last_addr, 32'h008);
    rd(8'h00, 32'h03);
    rd(8'h10, 32'h155);
    wb(1'b1, 8'h04, 32'h0);
    op(i_ret);
    rd(8'h00, 32'h0b);
    check(u_core.n_take, 32'h1);
    op(i_swi);
    check(u_core.last_addr, 32'h001);
    op(i_ei);
    op(i_di);
    rd(8'h00, 32'h03);
    op(i_swi);
    check(u_core.n_take, 32'h2);
    wb(1'b1, 8'h0c, 32'hff01);
    pset(8'hfe);
    rd(8'h04, 32'h4);
    wb(1'b1, 8'h04, 32'h0);
    pset(8'hff);
    pulse(3);
    wb(1'b1, 8'h0c, 32'hef01);
    pset(8'hf7);
    rd(8'h04, 32'h0);
    pset(8'hff);
    pulse(3);
    wb(1'b1, 8'h08, 32'h2);
    pset(8'hef);
    rd(8'h04, 32'h0);
    pset(8'he7);
    rd(8'h04, 32'h2);
    wb(1'b1, 8'h04, 32'h0);
    pulse(3);
    op(i_sleep);
    rd(8'h00, 32'h12);
    pset(8'hef);
    rd(8'h00, 32'h06);
    check(u_core.n_take, 32'h2);
    op(i_wdclr);
    rd(8'h00, 32'h07);
    pulse(1);
    rd(8'h00, 32'h03);
    pulse(2);
    rd(8'h00, 32'h01);
    op(i_sleep);
    pulse(1);
    rd(8'h00, 32'h02);
    op(i_sleep);
    pulse(2);
    rd(8'h00, 32'h00);
    pulse(0);
    rd(8'h00, 32'h03);
    summarize();
  end
endmodule

// ===== tb/reset_irq_properties.sv
/* Assertions on reset_irq ports: cause flags, reset, vectors.
   Assumes a bind onto reset_irq. */
module reset_irq_properties (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   power_on_i,
  input wire logic                   reset_pin_event_i,
  input wire logic                   watchdog_expire_i,
  input wire reset_irq_pkg::instr_t  instr_i,
  input wire logic                   core_reset_o,
  input wire logic                   sleeping_o,
  input wire reset_irq_pkg::vector_t vector_o,
  input wire reset_irq_pkg::cause_t  cause_o
);
  import reset_irq_pkg::*;
  // ----------
  // Properties
  // ----------
  logic pin;
  logic wdg;
  logic quiet;
  assign pin = reset_pin_event_i && !power_on_i && !watchdog_expire_i;
  assign wdg = watchdog_expire_i && !power_on_i;
  assign quiet = !(power_on_i || reset_pin_event_i || watchdog_expire_i);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_por; power_on_i |=> cause_o == 3'b011; endproperty
  a_por: assert property (p_por) else $error("power-on cause");
  property p_rst; core_reset_o == !quiet; endproperty
  a_rst: assert property (p_rst) else $error("reset output");
  property p_pin_run;
    pin && !sleeping_o |=> !cause_o.wake && $stable(cause_o[1:0]);
  endproperty
  a_pin_run: assert property (p_pin_run) else $error("pin run");
  property p_pin_slp; pin && sleeping_o |=> cause_o == 3'b010; endproperty
  a_pin_slp: assert property (p_pin_slp) else $error("pin sleep");
  property p_wd_run;
    wdg && !sleeping_o |=> cause_o[2:1] == 2'b00 && $stable(cause_o[0]);
  endproperty
  a_wd_run: assert property (p_wd_run) else $error("wdog run");
  property p_wd_slp; wdg && sleeping_o |=> cause_o == 3'b000; endproperty
  a_wd_slp: assert property (p_wd_slp) else $error("wdog sleep");
  property p_wdc;
    instr_i.wdt_clear && quiet && !sleeping_o
      |=> cause_o[1:0] == 2'b11 && $stable(cause_o.wake);
  endproperty
  a_wdc: assert property (p_wdc) else $error("wdog clear");
  property p_slp;
    instr_i.sleep && !instr_i.wdt_clear && quiet && !sleeping_o
      |=> cause_o[1:0] == 2'b10 && sleeping_o;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep entry");
  property p_vec;
    vector_o.take |-> vector_o.addr inside {10'h008, 10'h001};
  endproperty
  a_vec: assert property (p_vec) else $error("vector address");
  property p_once; vector_o.take |=> !vector_o.take; endproperty
  a_once: assert property (p_once) else $error("vector repeat");
  cover property (vector_o.take && vector_o.addr == 10'h008);
  cover property (vector_o.take && vector_o.addr == 10'h001);
  cover property ($fell(sleeping_o) && quiet);
endmodule

bind reset_irq reset_irq_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .power_on_i(power_on_i),
  .reset_pin_event_i(reset_pin_event_i),
  .watchdog_expire_i(watchdog_expire_i), .instr_i(instr_i),
  .core_reset_o(core_reset_o), .sleeping_o(sleeping_o),
  .vector_o(vector_o), .cause_o(cause_o)
);
